// >>> pbr_pkg.sv
`default_nettype none
package pbr_pkg;
	// register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_CAUSE = 4'h8;
	// control and status register fields
	localparam int CTRL_SWEN_BIT = 7;
	localparam int STAT_RDY_BIT = 0;
	localparam int STAT_HOLD_BIT = 1;
	localparam int STAT_SLEEP_BIT = 2;
	localparam int STAT_BODEN_BIT = 3;
	localparam int STAT_PUT_BIT = 4;
	localparam logic CTRL_SWEN_RST = 1'b1;
	// brown-out policies
	typedef enum logic [1:0] {
		BOM_OFF = 2'b00,
		BOM_SW = 2'b01,
		BOM_NOSLEEP = 2'b10,
		BOM_ON = 2'b11
	} pbr_bom_type;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int PUT_MS = 64;
	localparam int PUT_CYCLES = PUT_MS * CLK_MHZ * 1000;
	localparam int LR_DIV = 125;
	localparam int FILTER_NS = 400;
	localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int PUT_TICKS = PUT_MS * 1000;
	// reset cause bits
	localparam int NSRC = 8;
	typedef struct packed {
		logic [7:0] cause;
		logic [NSRC-1:0] src;
	} pbr_src_type;
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b10
	} pbr_st_type;
	typedef struct packed {
		logic [31:0] rdata;
		logic rvalid;
		logic bvalid;
		logic awready;
		logic wready;
		logic arready;
		logic aw_got;
		logic w_got;
		logic [3:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic swen;
		logic [7:0] cause;
	} pbr_bus_type;
endpackage
`default_nettype wire

// >>> pbr_sequencer.sv
`default_nettype none
module pbr_sequencer #(
	parameter int PUT_TICKS = pbr_pkg::PUT_TICKS,
	parameter int LR_DIV = pbr_pkg::LR_DIV,
	parameter int FILTER_CYCLES = pbr_pkg::FILTER_CYCLES
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic por_low_n, // power-on detector, low below operating level
	input wire logic bod_below, // supply under brown-out threshold
	input wire logic bod_ready, // analog detector settled
	input wire logic external_reset_pin_n, // external reset pin, active low
	input wire logic ext_reset_enable, // external reset pin enabled
	input wire logic wdt_timeout, // watchdog request
	input wire logic reset_instr, // reset instruction
	input wire logic stack_ovf, // call stack overflow
	input wire logic stack_unf, // call stack underflow
	input wire logic prog_exit, // programming mode left
	input wire logic osc_ready, // oscillator start-up done
	input wire logic sleep_req, // core in sleep
	input wire logic [1:0] brownout_mode_field, // policy
	input wire logic powerup_delay_disable_n, // 0 enables delay
	input wire logic brownout_level_select, // threshold selection
	input wire logic [3:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [3:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	output logic core_reset_n, // core reset, active low
	output logic bod_enable, // analog detector power enable
	output logic bod_level, // threshold selection to detector
	output logic wake_ok // sleep wake-up permitted
);
	if (PUT_TICKS < 1 || LR_DIV < 2 || LR_DIV > 65536 || FILTER_CYCLES < 1 || FILTER_CYCLES > 65535) begin
		$error("pbr_sequencer: bad parameter");
	end
	// analog and pin inputs pass two flops
	// they clear to zero, so the core stays held until the first real samples arrive
	localparam int NS = 8;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	assign raw = {osc_ready, bod_ready, bod_below, por_low_n, external_reset_pin_n,
		1'b0, 1'b0, 1'b0};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end
	logic por_ok, ext_ok, below_s, rdy_s, osc_s;
	assign ext_ok = s2_q[3];
	assign por_ok = s2_q[4];
	assign below_s = s2_q[5];
	assign rdy_s = s2_q[6];
	assign osc_s = s2_q[7];

	typedef struct packed {
		pbr_pkg::pbr_st_type st;
		logic [31:0] put_cnt;
		logic [15:0] lr_cnt;
		logic lr_tick;
		logic [15:0] filt_cnt;
		logic bor_trip;
		logic bod_en;
		logic wake;
		logic rst_n;
		logic lvl;
		pbr_pkg::pbr_bus_type bus;
	} pbr_state_type;
	pbr_state_type s_q, s_d;

	logic sync_src, bod_active, bor_hold, por_gate;
	pbr_pkg::pbr_bom_type mode;
	assign mode = pbr_pkg::pbr_bom_type'(brownout_mode_field);
	always_comb begin
		// detector active per policy
		case (mode)
			pbr_pkg::BOM_ON: bod_active = 1'b1;
			pbr_pkg::BOM_NOSLEEP: bod_active = !sleep_req;
			pbr_pkg::BOM_SW: bod_active = s_q.bus.swen;
			pbr_pkg::BOM_OFF: bod_active = 1'b0;
			default: bod_active = 1'b0;
		endcase
	end
	// protection only once detector is ready
	assign bor_hold = s_q.bod_en && rdy_s && s_q.bor_trip;
	// modes 11/10 wait at power-on for ready and good supply
	assign por_gate = (mode == pbr_pkg::BOM_ON || mode == pbr_pkg::BOM_NOSLEEP) ?
		(rdy_s && !below_s) : 1'b1;
	assign sync_src = wdt_timeout || reset_instr || stack_ovf || stack_unf || prog_exit;

	always_comb begin
		s_d = s_q;
		s_d.bod_en = bod_active;
		s_d.lvl = brownout_level_select;
		// low-rate tick for the delay counter
		s_d.lr_tick = 1'b0;
		if (s_q.lr_cnt == 16'(LR_DIV - 1)) begin
			s_d.lr_cnt = 16'h0000;
			s_d.lr_tick = 1'b1;
		end else begin
			s_d.lr_cnt = s_q.lr_cnt + 16'h0001;
		end
		// dip filter
		if (s_q.bod_en && below_s) begin
			if (s_q.filt_cnt != 16'(FILTER_CYCLES))
				s_d.filt_cnt = s_q.filt_cnt + 16'h0001;
		end else begin
			s_d.filt_cnt = 16'h0000;
		end
		s_d.bor_trip = (s_d.filt_cnt == 16'(FILTER_CYCLES));
		// wake gating: mode 10 waits for ready
		s_d.wake = (mode == pbr_pkg::BOM_NOSLEEP) ? rdy_s : 1'b1;
		case (s_q.st)
			pbr_pkg::ST_HOLD: begin
				s_d.rst_n = 1'b0;
				s_d.put_cnt = 32'h00000000;
				if (por_ok && !bor_hold && por_gate)
					s_d.st = pbr_pkg::ST_WAIT;
			end
			pbr_pkg::ST_WAIT: begin
				s_d.rst_n = 1'b0;
				if (powerup_delay_disable_n || s_q.put_cnt == 32'(PUT_TICKS)) begin
					// a synchronous source still asserted keeps the core held
					if (osc_s && (ext_ok || !ext_reset_enable) && !sync_src) begin
						s_d.st = pbr_pkg::ST_RUN;
						s_d.rst_n = 1'b1;
					end
				end else if (s_q.lr_tick) begin
					s_d.put_cnt = s_q.put_cnt + 32'h00000001;
				end
			end
			pbr_pkg::ST_RUN: begin
				s_d.rst_n = 1'b1;
				if (ext_reset_enable && !ext_ok) begin
					s_d.st = pbr_pkg::ST_WAIT;
					s_d.rst_n = 1'b0;
					s_d.put_cnt = 32'(PUT_TICKS);
				end
				if (sync_src) begin
					s_d.st = pbr_pkg::ST_WAIT;
					s_d.rst_n = 1'b0;
					s_d.put_cnt = 32'(PUT_TICKS);
				end
			end
			default: s_d.st = pbr_pkg::ST_HOLD;
		endcase
		// power-on, brown-out or programming-mode exit restarts full sequence
		if (!por_ok || bor_hold || prog_exit) begin
			s_d.st = pbr_pkg::ST_HOLD;
			s_d.rst_n = 1'b0;
		end
		if (!por_ok) s_d.bus.cause[0] = 1'b1;
		if (bor_hold) s_d.bus.cause[1] = 1'b1;
		if (ext_reset_enable && !ext_ok) s_d.bus.cause[2] = 1'b1;
		// AXI4-Lite slave
		if (s_q.bus.awready && s_axi_awvalid) begin
			s_d.bus.awready = 1'b0;
			s_d.bus.aw_got = 1'b1;
			s_d.bus.awaddr = s_axi_awaddr;
		end
		if (s_q.bus.wready && s_axi_wvalid) begin
			s_d.bus.wready = 1'b0;
			s_d.bus.w_got = 1'b1;
			s_d.bus.wdata = s_axi_wdata;
			s_d.bus.wstrb = s_axi_wstrb;
		end
		if (s_q.bus.aw_got && s_q.bus.w_got && !s_q.bus.bvalid) begin
			s_d.bus.bvalid = 1'b1;
			s_d.bus.bresp = 2'b00;
			if (s_q.bus.awaddr == pbr_pkg::OFF_CTRL) begin
				if (s_q.bus.wstrb[0])
					s_d.bus.swen = s_q.bus.wdata[pbr_pkg::CTRL_SWEN_BIT];
			end else if (s_q.bus.awaddr == pbr_pkg::OFF_CAUSE) begin
				if (s_q.bus.wstrb[0])
					s_d.bus.cause = s_d.bus.cause & ~s_q.bus.wdata[7:0] |
						{5'h00, !por_ok, bor_hold, ext_reset_enable && !ext_ok};
			end else if (s_q.bus.awaddr != pbr_pkg::OFF_STATUS) begin
				s_d.bus.bresp = 2'b10;
			end
		end
		if (s_q.bus.bvalid && s_axi_bready) begin
			s_d.bus.bvalid = 1'b0;
			s_d.bus.aw_got = 1'b0;
			s_d.bus.w_got = 1'b0;
			s_d.bus.awready = 1'b1;
			s_d.bus.wready = 1'b1;
		end
		if (s_q.bus.arready && s_axi_arvalid) begin
			s_d.bus.arready = 1'b0;
			s_d.bus.rvalid = 1'b1;
			s_d.bus.rresp = 2'b00;
			s_d.bus.rdata = 32'h00000000;
			case (s_axi_araddr)
				pbr_pkg::OFF_CTRL: s_d.bus.rdata[pbr_pkg::CTRL_SWEN_BIT] = s_q.bus.swen;
				pbr_pkg::OFF_STATUS: begin
					s_d.bus.rdata[pbr_pkg::STAT_RDY_BIT] = s_q.bod_en && rdy_s;
					s_d.bus.rdata[pbr_pkg::STAT_HOLD_BIT] = !s_q.rst_n;
					s_d.bus.rdata[pbr_pkg::STAT_SLEEP_BIT] = sleep_req;
					s_d.bus.rdata[pbr_pkg::STAT_BODEN_BIT] = s_q.bod_en;
					s_d.bus.rdata[pbr_pkg::STAT_PUT_BIT] = (s_q.st == pbr_pkg::ST_WAIT);
				end
				pbr_pkg::OFF_CAUSE: s_d.bus.rdata[7:0] = s_q.bus.cause;
				default: s_d.bus.rresp = 2'b10;
			endcase
		end
		if (s_q.bus.rvalid && s_axi_rready) begin
			s_d.bus.rvalid = 1'b0;
			s_d.bus.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.st <= pbr_pkg::ST_HOLD;
			s_q.bus.awready <= 1'b1;
			s_q.bus.wready <= 1'b1;
			s_q.bus.arready <= 1'b1;
			s_q.bus.swen <= pbr_pkg::CTRL_SWEN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.bus.awready;
	assign s_axi_wready = s_q.bus.wready;
	assign s_axi_bvalid = s_q.bus.bvalid;
	assign s_axi_bresp = s_q.bus.bresp;
	assign s_axi_arready = s_q.bus.arready;
	assign s_axi_rvalid = s_q.bus.rvalid;
	assign s_axi_rdata = s_q.bus.rdata;
	assign s_axi_rresp = s_q.bus.rresp;
	assign core_reset_n = s_q.rst_n;
	assign bod_enable = s_q.bod_en;
	assign bod_level = s_q.lvl;
	assign wake_ok = s_q.wake;

	// properties sample on the same edge as the state register
	a_por_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		!por_ok |=> !core_reset_n) else $error("reset released under power-on");
	a_put_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == pbr_pkg::ST_WAIT && !powerup_delay_disable_n && s_q.put_cnt != 32'(PUT_TICKS))
		|=> !core_reset_n) else $error("reset released while delay counting");
	a_src_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		sync_src |=> !core_reset_n) else $error("source did not reset");
	a_bor_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		bor_hold |=> !core_reset_n) else $error("brown-out did not hold reset");
	a_mode_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == pbr_pkg::BOM_OFF) [*2] |-> !bod_enable) else $error("detector on in mode 00");
	a_mode_sleep: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == pbr_pkg::BOM_NOSLEEP && sleep_req) |=> !bod_enable) else $error("mode 10 sleep");
	a_mode_on: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == pbr_pkg::BOM_ON) |=> bod_enable && wake_ok) else $error("mode 11 detector off");
	a_sw_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == pbr_pkg::BOM_SW) |=> bod_enable == $past(s_q.bus.swen)) else $error("sw enable");
	a_run_needs: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(core_reset_n) |-> $past(osc_s)) else $error("run before oscillator");
	a_level_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> bod_level == $past(brownout_level_select)) else $error("threshold select not passed on");
	a_wake_ready: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == pbr_pkg::BOM_NOSLEEP && !rdy_s) |=> !wake_ok) else $error("wake allowed before ready");
	a_put_start: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.st == pbr_pkg::ST_WAIT && (!por_ok || bor_hold)) |=> s_q.st == pbr_pkg::ST_HOLD)
		else $error("delay ran under power-on or brown-out");
	a_dip_filter: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(s_q.bor_trip) |-> $past(below_s, FILTER_CYCLES)) else $error("dip shorter than filter tripped");
endmodule // pbr_sequencer
`default_nettype wire

// >>> pbr_supply_model.sv
`default_nettype none
module pbr_supply_model (
	input wire logic aclk, // system clock
	input wire logic supply_ok, // supply above operating level
	input wire logic dip, // supply under brown-out threshold
	input wire logic rdy_go, // detector allowed to settle
	input wire logic enable, // detector power from the block
	output logic por_low_n, // power-on detector
	output logic bod_below, // brown-out comparator
	output logic bod_ready // detector settled
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] sh = 2'b00;
	logic t = 1'b0;
	always @(posedge aclk) begin
		sh <= {sh[0], enable & rdy_go};
		t <= ~t;
	end
	assign por_low_n = supply_ok;
	assign bod_ready = sh[1];
	// an unpowered comparator output is meaningless, so it toggles
	assign bod_below = enable ? (dip | ~supply_ok) : t;
endmodule // pbr_supply_model
`default_nettype wire

// >>> power_on_brownout_reset_sequencer_tb_top.sv
`default_nettype none
module power_on_brownout_reset_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, sup = 0, dip = 1, rgo = 0, pin = 1, exen = 1, osc = 1, slp = 0, pden = 0, lvl = 0;
	logic [4:0] rs = 0;
	logic [1:0] mode = 2'b11, rsp;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	wire logic pl, bb, brdy, awr, wr_, bv, arr, rv, crn, ben, blv, wok;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int err_total = 0, num_checks = 0, c[2];
	localparam int PT = 4, LD = 2, FC = 4;
	initial forever #4 aclk = ~aclk;
	pbr_supply_model sup_u (.aclk(aclk), .supply_ok(sup), .dip(dip), .rdy_go(rgo), .enable(ben),
		.por_low_n(pl), .bod_below(bb), .bod_ready(brdy));
	pbr_sequencer #(.PUT_TICKS(PT), .LR_DIV(LD), .FILTER_CYCLES(FC)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.por_low_n(pl), .bod_below(bb), .bod_ready(brdy), .external_reset_pin_n(pin), .ext_reset_enable(exen),
		.wdt_timeout(rs[0]), .reset_instr(rs[1]), .stack_ovf(rs[2]), .stack_unf(rs[3]), .prog_exit(rs[4]),
		.osc_ready(osc), .sleep_req(slp), .brownout_mode_field(mode), .powerup_delay_disable_n(pden),
		.brownout_level_select(lvl), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.core_reset_n(crn), .bod_enable(ben), .bod_level(blv), .wake_ok(wok));
	task automatic stop_test;
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic hang;
		err_total++;
		stop_test();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr_) wv <= 0;
			if (bv) break;
		end
		if (n == 50) hang();
		rsp = bresp;
		br <= 0;
	endtask
	task automatic rdr(input logic [3:0] a);
		int n;
		@(posedge aclk);
		ara <= a; arv <= 1; rr <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arr) arv <= 0;
			if (rv) break;
		end
		if (n == 50) hang();
		rd = rdata; rsp = rresp;
		rr <= 0;
	endtask
	// waits for core reset to reach v, returning the cycles taken
	task automatic wt(input logic v, output int n);
		for (n = 0; n < 300 && crn !== v; n++) @(posedge aclk);
		if (n == 300) hang();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	initial begin
		int n;
		cyc(10);
		aresetn <= 1;
		rdr(pbr_pkg::OFF_CTRL);
		chk("ctrl_reset", rd, 32'h0000_0080);
		chk("ctrl_rresp", rsp, 2'b00);
		wr(4'hC, 32'h0000_0000);
		chk("unmapped_resp", rsp, 2'b10);
		sup <= 1; dip <= 0; cyc(40);
		chk("hold_until_ready", crn, 0);
		rgo <= 1; wt(1, n);
		lvl <= 1; cyc(4);
		chk("level", blv, 1);
		dip <= 1; cyc(2); dip <= 0; cyc(20);
		chk("short_dip", crn, 1);
		dip <= 1; cyc(20);
		chk("long_dip", crn, 0);
		dip <= 0; wt(1, n);
		for (int i = 0; i < 5; i++) begin
			rs[i] <= 1; cyc(1); rs[i] <= 0; cyc(1);
			chk("src_reset", crn, 0);
			wt(1, n);
		end
		pin <= 0; cyc(5);
		chk("pin_hold", crn, 0);
		pin <= 1; wt(1, n);
		rdr(pbr_pkg::OFF_CAUSE);
		chk("cause_set", rd, 32'h0000_0007);
		wr(pbr_pkg::OFF_CAUSE, 32'h0000_00FF);
		rdr(pbr_pkg::OFF_CAUSE);
		chk("cause_clear", rd, 32'h0000_0000);
		exen <= 0; pin <= 0; cyc(5);
		chk("pin_off", crn, 1);
		exen <= 1; osc <= 0; pin <= 0; cyc(5); pin <= 1; cyc(20);
		chk("osc_wait", crn, 0);
		osc <= 1; wt(1, n);
		mode <= 2'b01; wr(pbr_pkg::OFF_CTRL, 32'h0); cyc(5);
		chk("sw_off", ben, 0);
		chk("ctrl_wresp", rsp, 2'b00);
		rdr(pbr_pkg::OFF_STATUS);
		chk("rdy_off", rd[pbr_pkg::STAT_RDY_BIT], 0);
		dip <= 1; cyc(20);
		chk("off_no_reset", crn, 1);
		dip <= 0; wr(pbr_pkg::OFF_CTRL, 32'h80); cyc(5);
		rdr(pbr_pkg::OFF_STATUS);
		chk("rdy_on", rd[pbr_pkg::STAT_RDY_BIT], 1);
		chk("status_on", rd, 32'h0000_0009);
		slp <= 1; cyc(5);
		chk("sw_sleep", ben, 1);
		mode <= 2'b10; cyc(8);
		chk("nosleep_off", ben, 0);
		chk("nosleep_wake", wok, 0);
		mode <= 2'b11; cyc(8);
		chk("on_sleep", ben, 1);
		chk("on_wake", wok, 1);
		slp <= 0; mode <= 2'b00; cyc(5);
		chk("mode_off", ben, 0);
		mode <= 2'b11;
		for (int p = 0; p < 2; p++) begin
			pden <= p[0]; sup <= 0; cyc(20);
			chk("por_hold", crn, 0);
			sup <= 1; wt(1, c[p]);
		end
		chk("delay_min", 32'(c[0] - c[1] >= PT * LD - LD + 1), 1);
		chk("delay_max", 32'(c[0] - c[1] <= PT * LD), 1);
		stop_test();
	end
endmodule // power_on_brownout_reset_sequencer_tb_top
`default_nettype wire
